//--- logic/flash_cmd_status.sv
// flash command, status and protection registers behind a Wishbone slave
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - disallowed protection writes leave register unchanged
// - only listed scenario transitions are accepted
// - protection read returns scenario in force
// - normal modes: flag access per bit class
// - special modes expose verify-error and idle
// - buffer-empty reads ready; write one clears
// - zero to buffer-empty mid-sequence aborts, errors
// - interrupt when flag and enable both set
// - complete clears with launch, sets when drained
// - protected target sets violation, except erase-verify; blocks launch
// - sequence, code or stop errors; blocks launch
// - erased flag from verify; cleared on launch
// - special verify failure flag blocks launch
// - idle flag low while operation active
// - command bits 6,5,2,0 only during sequence
// - four command codes recognised
// - unknown command code sets access error
// - factory test slot reads zero
// - no divider write means no execution
module flash_cmd_status
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] PROT_INIT = PROT_RESET,
  parameter int ENGINE_CYCLES = OP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic special_mode_i,
  input wire logic cpu_stop_i,
  input wire logic array_blank_i,
  output logic buffer_empty_irq_o,
  output logic command_complete_irq_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    seq_e seq;
    logic cc;
    logic protection_violation_flag;
    logic access_error_flag;
    logic blank;
    logic fail;
    logic [7:0] prot;
    logic [1:0] irq_en;
    logic [6:0] divider;
    logic div_loaded;
    logic [15:0] addr;
    logic [7:0] cmd;
    logic buf_valid;
    logic [7:0] buf_cmd;
  } regs_s;
  regs_s s;
  regs_s next_s;

  logic take;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic [7:0] status;
  logic prot_ok;
  logic addr_prot;
  logic eng_busy;
  logic eng_done;
  logic eng_verify;
  logic eng_blank;
  logic eng_start;
  logic cmd_legal;
  logic launch_try;
  logic launch_blocked;
  logic launch_ok;

  prot_check u_prot (
    .prot_i(s.prot),
    .new_prot_i(wbyte),
    .addr_i(s.addr),
    .allowed_o(prot_ok),
    .protected_o(addr_prot)
  );

  // the buffered command moves on as soon as the engine is free
  assign eng_start = s.buf_valid && !eng_busy;

  op_engine #(
    .CYCLES(ENGINE_CYCLES)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(eng_start),
    .cmd_i(s.buf_cmd),
    .array_blank_i(array_blank_i),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .verify_o(eng_verify),
    .blank_o(eng_blank)
  );

  always_comb begin
    take = cyc_i && stb_i && !s.ack;
    wr = take && we_i && sel_i[0];
    idx = adr_i[7:2];
    wbyte = dat_i[7:0];
    cmd_legal = s.cmd == CMD_ERASE_VERIFY || s.cmd == CMD_WORD_PROGRAM
             || s.cmd == CMD_SECTOR_ERASE || s.cmd == CMD_MASS_ERASE;
    status = '0;
    status[ST_BUF_EMPTY] = !s.buf_valid;
    status[ST_CMD_DONE] = s.cc;
    status[ST_PROT_VIOL] = s.protection_violation_flag;
    status[ST_ACC_ERR] = s.access_error_flag;
    status[ST_ERASED] = s.blank;
    status[ST_VERIFY_ERR] = special_mode_i && s.fail;
    status[ST_IDLE] = special_mode_i && !eng_busy && !s.buf_valid;
    launch_try = wr && idx == IDX_STATUS && wbyte[ST_BUF_EMPTY] && s.seq == SEQ_CMD;
    // any pending error freezes launching until software clears it
    launch_blocked = s.protection_violation_flag || s.access_error_flag || (special_mode_i && s.fail) || s.buf_valid;
    // a launch that is accepted and queued; used by the checks below
    launch_ok = launch_try && !launch_blocked && s.div_loaded && cmd_legal
             && (s.cmd == CMD_ERASE_VERIFY || !addr_prot);
  end

  always_comb begin
    next_s = s;
    next_s.ack = take;
    if (take && !we_i) begin
      next_s.rdata = '0;
      case (idx)
        IDX_DIVIDER: next_s.rdata[7:0] = {s.div_loaded, s.divider};
        IDX_CONFIG: next_s.rdata[7:0] = {s.irq_en, 6'h00};
        IDX_PROTECT: next_s.rdata[7:0] = s.prot;
        IDX_STATUS: next_s.rdata[7:0] = status;
        IDX_COMMAND: next_s.rdata[7:0] = (s.seq != SEQ_IDLE) ? s.cmd : 8'h00;
        IDX_TEST: next_s.rdata = '0;
        default: next_s.rdata = '0;
      endcase
    end
    if (wr) begin
      case (idx)
        IDX_DIVIDER: begin
          next_s.divider = wbyte[6:0];
          next_s.div_loaded = 1'b1;
        end
        IDX_CONFIG: next_s.irq_en = wbyte[7:6];
        IDX_PROTECT: begin
          if (prot_ok) begin
            next_s.prot = wbyte;
          end
        end
        IDX_STATUS: begin
          // clears come first so an error raised by the same write still stands
          if (wbyte[ST_PROT_VIOL]) begin
            next_s.protection_violation_flag = 1'b0;
          end
          if (wbyte[ST_ACC_ERR]) begin
            next_s.access_error_flag = 1'b0;
          end
          if (special_mode_i && wbyte[ST_VERIFY_ERR]) begin
            next_s.fail = 1'b0;
          end
          if (s.seq != SEQ_IDLE && !wbyte[ST_BUF_EMPTY]) begin
            next_s.seq = SEQ_IDLE;
            next_s.access_error_flag = 1'b1;
          end
          if (s.seq == SEQ_ADDR && wbyte[ST_BUF_EMPTY]) begin
            next_s.seq = SEQ_IDLE;
            next_s.access_error_flag = 1'b1;
          end
        end
        IDX_COMMAND: begin
          if (s.seq == SEQ_ADDR) begin
            next_s.cmd = wbyte & CMD_BITS_MASK;
            next_s.seq = SEQ_CMD;
          end else begin
            next_s.seq = SEQ_IDLE;
            next_s.access_error_flag = 1'b1;
          end
        end
        IDX_ARRAY: begin
          // a misaligned word or a second array write breaks the sequence
          if (s.seq != SEQ_IDLE || dat_i[0]) begin
            next_s.seq = SEQ_IDLE;
            next_s.access_error_flag = 1'b1;
          end else begin
            next_s.addr = dat_i[15:0];
            next_s.seq = SEQ_ADDR;
          end
        end
        default: begin
          // writes to unmapped indices between steps violate the sequence
          if (s.seq != SEQ_IDLE) begin
            next_s.seq = SEQ_IDLE;
            next_s.access_error_flag = 1'b1;
          end
        end
      endcase
      if (launch_try) begin
        next_s.seq = SEQ_IDLE;
        if (launch_blocked) begin
          next_s.access_error_flag = 1'b1;
        end else if (!s.div_loaded || !cmd_legal) begin
          next_s.access_error_flag = 1'b1;
        end else if (s.cmd != CMD_ERASE_VERIFY && addr_prot) begin
          next_s.protection_violation_flag = 1'b1;
        end else begin
          next_s.buf_valid = 1'b1;
          next_s.buf_cmd = s.cmd;
          next_s.cc = 1'b0;
          next_s.blank = 1'b0;
        end
      end
    end
    if (eng_start) begin
      next_s.buf_valid = 1'b0;
    end
    // complete only when nothing is queued behind the finished operation
    if (eng_done && !s.buf_valid && !next_s.buf_valid) begin
      next_s.cc = 1'b1;
    end
    if (eng_done && eng_verify) begin
      if (eng_blank) begin
        next_s.blank = 1'b1;
      end else if (special_mode_i) begin
        next_s.fail = 1'b1;
      end
    end
    if (cpu_stop_i && !s.cc) begin
      next_s.access_error_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{ack: 1'b0, rdata: '0, seq: SEQ_IDLE, cc: 1'b1, protection_violation_flag: 1'b0, access_error_flag: 1'b0,
             blank: 1'b0, fail: 1'b0, prot: PROT_INIT, irq_en: 2'b00, divider: '0,
             div_loaded: 1'b0, addr: '0, cmd: '0, buf_valid: 1'b0, buf_cmd: '0};
    end else begin
      s <= next_s;
    end
  end

  assign ack_o = s.ack;
  assign dat_o = s.rdata;
  assign buffer_empty_irq_o = s.irq_en[1] && !s.buf_valid;
  assign command_complete_irq_o = s.irq_en[0] && s.cc;

  chk_prot_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_PROTECT && !prot_ok) |=> s.prot == $past(s.prot))
    else $error("protection changed on a disallowed write");
  chk_prot_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && idx == IDX_PROTECT) |=> (ack_o && dat_o[7:0] == $past(s.prot)))
    else $error("protection read does not match register");
  chk_normal_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && idx == IDX_STATUS && !special_mode_i) |=> (dat_o[3] == 1'b0 && dat_o[1:0] == 2'b00))
    else $error("hidden status bits visible in normal mode");
  chk_abort_error: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_STATUS && s.seq != SEQ_IDLE && !wbyte[ST_BUF_EMPTY]) |=> (s.access_error_flag && s.seq == SEQ_IDLE))
    else $error("aborted sequence did not flag access error");
  chk_irq_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    (command_complete_irq_o == (s.irq_en[0] && status[ST_CMD_DONE]))
      && (buffer_empty_irq_o == (s.irq_en[1] && status[ST_BUF_EMPTY])))
    else $error("interrupt does not follow flag and enable");
  chk_launch_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (launch_try && !launch_blocked && s.div_loaded && cmd_legal && !addr_prot) |=> (!s.cc ##1 !s.cc))
    else $error("complete flag not cleared by launch");
  chk_blocked_launch: assert property (@(posedge clk_i) disable iff (rst_i)
    (launch_try && (s.protection_violation_flag || s.access_error_flag)) |=> (s.access_error_flag && s.seq == SEQ_IDLE && !$rose(s.buf_valid)))
    else $error("launch taken while an error flag stood");
  chk_cmd_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && idx == IDX_COMMAND) |=> (dat_o[7] == 1'b0 && dat_o[4:3] == 2'b00 && dat_o[1] == 1'b0))
    else $error("unreadable command bits visible");
  chk_test_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && idx == IDX_TEST) |=> dat_o == 32'h0000_0000)
    else $error("factory test slot not zero");
  chk_idle_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && idx == IDX_STATUS && special_mode_i && eng_busy) |=> !dat_o[ST_IDLE])
    else $error("idle flag high during operation");
  chk_divider_needed: assert property (@(posedge clk_i) disable iff (rst_i)
    (launch_try && !s.div_loaded) |=> (s.access_error_flag && !s.buf_valid))
    else $error("command ran without divider setup");
  chk_prot_moves: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_PROTECT && prot_ok) |=> s.prot == $past(wbyte))
    else $error("allowed protection write not taken");
  chk_empty_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && idx == IDX_STATUS) |=> dat_o[ST_BUF_EMPTY] == !$past(s.buf_valid))
    else $error("buffer-empty bit reads wrong");
  chk_zero_outside: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_STATUS && s.seq == SEQ_IDLE && !wbyte[ST_BUF_EMPTY] && !s.access_error_flag && !cpu_stop_i)
      |=> !s.access_error_flag)
    else $error("zero to buffer-empty outside a sequence flagged error");
  chk_cc_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_STATUS && !launch_try && !eng_done) |=> s.cc == $past(s.cc))
    else $error("complete flag changed by a write");
  chk_cc_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_done && (s.buf_valid || launch_ok)) |=> !s.cc)
    else $error("complete flag set with a command queued");
  chk_cc_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_done && !s.buf_valid && !launch_ok) |=> s.cc)
    else $error("complete flag not set when drained");
  chk_viol_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (launch_try && !launch_blocked && s.div_loaded && cmd_legal && s.cmd != CMD_ERASE_VERIFY && addr_prot)
      |=> (s.protection_violation_flag && !$rose(s.buf_valid)))
    else $error("protected target launched");
  chk_protection_violation_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.protection_violation_flag && !(wr && idx == IDX_STATUS && wbyte[ST_PROT_VIOL])) |=> s.protection_violation_flag)
    else $error("violation flag cleared without a write of one");
  chk_access_error_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.access_error_flag && !(wr && idx == IDX_STATUS && wbyte[ST_ACC_ERR])) |=> s.access_error_flag)
    else $error("access error cleared without a write of one");
  chk_cmd_outside: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_COMMAND && s.seq != SEQ_ADDR) |=> s.access_error_flag)
    else $error("command write outside sequence not flagged");
  chk_stop_error: assert property (@(posedge clk_i) disable iff (rst_i)
    (cpu_stop_i && !s.cc) |=> s.access_error_flag)
    else $error("stop during a command not flagged");
  chk_blank_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_done && eng_verify && eng_blank) |=> s.blank)
    else $error("erased flag not set by a clean verify");
  chk_erased_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.blank && !launch_ok) |=> s.blank)
    else $error("erased flag lost without a launch");
  chk_verify_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_done && eng_verify && !eng_blank && special_mode_i) |=> s.fail)
    else $error("verify failure not flagged");
  chk_fail_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.fail && !(wr && idx == IDX_STATUS && special_mode_i && wbyte[ST_VERIFY_ERR])) |=> s.fail)
    else $error("verify-error cleared without a write of one");
  chk_bad_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (launch_try && !cmd_legal) |=> (s.access_error_flag && !$rose(s.buf_valid)))
    else $error("unknown command code not flagged");
  cov_launch: cover property (@(posedge clk_i) disable iff (rst_i) eng_start);
  cov_pipeline: cover property (@(posedge clk_i) disable iff (rst_i) eng_busy && s.buf_valid);
  cov_violation: cover property (@(posedge clk_i) disable iff (rst_i) $rose(s.protection_violation_flag));
  cov_blank: cover property (@(posedge clk_i) disable iff (rst_i) $rose(s.blank));
  cov_cc_held: cover property (@(posedge clk_i) disable iff (rst_i) eng_done && s.buf_valid);
endmodule : flash_cmd_status
`default_nettype wire

//--- logic/flash_cmd_pkg.sv
// constants shared by the flash command, status and protection front end
package flash_cmd_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_DIVIDER = 6'h02;
  localparam logic [5:0] IDX_CONFIG = 6'h03;
  localparam logic [5:0] IDX_PROTECT = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h05;
  localparam logic [5:0] IDX_COMMAND = 6'h06;
  localparam logic [5:0] IDX_TEST = 6'h07;
  localparam logic [5:0] IDX_ARRAY = 6'h08;
  // status bit positions
  localparam int ST_BUF_EMPTY = 7;
  localparam int ST_CMD_DONE = 6;
  localparam int ST_PROT_VIOL = 5;
  localparam int ST_ACC_ERR = 4;
  localparam int ST_ERASED = 2;
  localparam int ST_VERIFY_ERR = 1;
  localparam int ST_IDLE = 0;
  // config and divider fields
  localparam int CFG_BE_IE = 7;
  localparam int CFG_CC_IE = 6;
  localparam int DIV_LOADED = 7;
  // protection fields
  localparam int PR_OPEN = 7;
  localparam int PR_HDIS = 5;
  localparam int PR_LDIS = 2;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  // command codes and readable command bits
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
  localparam logic [7:0] CMD_WORD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
  localparam logic [7:0] CMD_BITS_MASK = 8'h65;
  // allowed targets per source scenario, bit n = target n
  localparam logic [63:0] SCEN_ALLOWED = {8'hFF, 8'h5A, 8'h3C, 8'h18, 8'h08, 8'h0C, 8'h0A, 8'h0F};
  // protected range bases
  localparam logic [15:0] HIGH_BASE_0 = 16'hF800;
  localparam logic [15:0] HIGH_BASE_1 = 16'hF000;
  localparam logic [15:0] HIGH_BASE_2 = 16'hE000;
  localparam logic [15:0] HIGH_BASE_3 = 16'hC000;
  localparam logic [15:0] LOW_BASE = 16'h4000;
  localparam logic [15:0] LOW_TOP_0 = 16'h43FF;
  localparam logic [15:0] LOW_TOP_1 = 16'h47FF;
  localparam logic [15:0] LOW_TOP_2 = 16'h4FFF;
  localparam logic [15:0] LOW_TOP_3 = 16'h5FFF;
  // array operation length, a stand-in for the timing engine
  localparam int OP_CYCLES = 16;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD = 2'b10
  } seq_e;
endpackage : flash_cmd_pkg

//--- logic/prot_check.sv
// protection scenario index, transition check and address protection test
`timescale 1ns/100ps
`default_nettype none
module prot_check
  import flash_cmd_pkg::*;
(
  input wire logic [7:0] prot_i,
  input wire logic [7:0] new_prot_i,
  input wire logic [15:0] addr_i,
  output logic allowed_o,
  output logic protected_o
);
  logic [2:0] from_idx;
  logic [2:0] to_idx;
  logic in_high;
  logic in_low;
  logic ranged;
  logic [15:0] high_base;
  logic [15:0] low_top;

  function automatic logic [2:0] scen(input logic [7:0] p);
    // open: {1,h,l}; closed: {0,l,h}
    scen = p[PR_OPEN] ? {1'b1, p[PR_HDIS], p[PR_LDIS]} : {1'b0, p[PR_LDIS], p[PR_HDIS]};
  endfunction : scen

  always_comb begin
    from_idx = scen(prot_i);
    to_idx = scen(new_prot_i);
    allowed_o = SCEN_ALLOWED[{3'(from_idx), to_idx}];
    case (prot_i[4:3])
      2'b00: high_base = HIGH_BASE_0;
      2'b01: high_base = HIGH_BASE_1;
      2'b10: high_base = HIGH_BASE_2;
      default: high_base = HIGH_BASE_3;
    endcase
    case (prot_i[1:0])
      2'b00: low_top = LOW_TOP_0;
      2'b01: low_top = LOW_TOP_1;
      2'b10: low_top = LOW_TOP_2;
      default: low_top = LOW_TOP_3;
    endcase
    in_high = !prot_i[PR_HDIS] && addr_i >= high_base;
    in_low = !prot_i[PR_LDIS] && addr_i >= LOW_BASE && addr_i <= low_top;
    ranged = in_high || in_low;
    // open: ranges are protected; closed: ranges are the only writable areas
    protected_o = prot_i[PR_OPEN] ? ranged : !ranged;
  end
endmodule : prot_check
`default_nettype wire

//--- logic/op_engine.sv
// stand-in array operation engine: fixed length, reports erase-verify result
`timescale 1ns/100ps
`default_nettype none
module op_engine
  import flash_cmd_pkg::*;
#(
  parameter int CYCLES = OP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] cmd_i,
  input wire logic array_blank_i,
  output logic busy_o,
  output logic done_o,
  output logic verify_o,
  output logic blank_o
);
  typedef struct packed {
    logic busy;
    logic done;
    logic verify;
    logic blank;
    logic [15:0] count;
  } eng_s;
  eng_s s;
  eng_s next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.busy) begin
      if (s.count == 16'(CYCLES - 1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.blank = array_blank_i;
      end else begin
        next_s.count = s.count + 16'h0001;
      end
    end else if (start_i) begin
      next_s.busy = 1'b1;
      next_s.count = 16'h0000;
      next_s.verify = (cmd_i == CMD_ERASE_VERIFY);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;
  assign verify_o = s.verify;
  assign blank_o = s.blank;
endmodule : op_engine
`default_nettype wire

//--- sim/wb_host.sv
// register bus master standing in for software on the cpu side
`timescale 1ns/100ps
`default_nettype none
module wb_host
  import flash_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  output logic hung_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, hung_o} = '0;
  end

  // the request is held until ack is sampled high, then released at that edge
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    q = '0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) break;
    end
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released data lines must not keep looking valid
    dat_o <= ~d;
    if (n == 50) hung_o <= 1'b1;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, {24'h000000, d}, q);
  endtask : wr

  task automatic rd(input logic [5:0] idx, output logic [7:0] q);
    logic [31:0] w;
    xfer(1'b0, idx, 32'h00000000, w);
    q = w[7:0];
  endtask : rd

  task automatic arr(input logic [15:0] a);
    logic [31:0] q;
    xfer(1'b1, IDX_ARRAY, {16'h1234, a}, q);
  endtask : arr

  // address, command, launch, with nothing written in between
  task automatic seq(input logic [15:0] a, input logic [7:0] cmd);
    arr(a);
    wr(IDX_COMMAND, cmd);
    wr(IDX_STATUS, 8'h80);
  endtask : seq
endmodule : wb_host
`default_nettype wire

//--- sim/test_flash_command_status_protect.sv
// self-checking bench for the flash command, status and protection registers
`timescale 1ns/100ps
`default_nettype none
module test_flash_command_status_protect
  import flash_cmd_pkg::*;
  ;
  logic clk, rst, cyc, stb, we, ack, special, cpu_stop, blank, be_irq, cc_irq, hung;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [7:0] q;
  int n_fail = 0;
  int checks = 0;
  localparam logic [7:0] OK_TO [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

  // long enough for a second command to be queued behind a running one
  flash_cmd_status #(.ENGINE_CYCLES(20)) u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .special_mode_i(special), .cpu_stop_i(cpu_stop), .array_blank_i(blank),
    .buffer_empty_irq_o(be_irq), .command_complete_irq_o(cc_irq));
  wb_host u_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hung_o(hung));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  always @(posedge hung) begin
    n_fail++;
    $display("[ERR] bus ack expected 1 seen 0");
    wrap_up();
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rc(input string what, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(idx, v);
    chk(what, exp, v);
  endtask : rc

  task automatic wait_done();
    logic [7:0] v;
    for (int i = 0; i < 40; i++) begin
      u_host.rd(IDX_STATUS, v);
      if (v[ST_CMD_DONE] === 1'b1) return;
    end
    n_fail++;
    $display("[ERR] completion expected 1 seen 0");
    wrap_up();
  endtask : wait_done

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  // open bit 7, high disable bit 5, low disable bit 2; other bits kept at one
  function automatic logic [7:0] enc(input logic [2:0] i);
    return i[2] ? {2'b11, i[1], 2'b11, i[0], 2'b11} : {2'b01, i[0], 2'b11, i[1], 2'b11};
  endfunction : enc

  task automatic t_access();
    rc("status", IDX_STATUS, 8'hC0);
    rc("command idle", IDX_COMMAND, 8'h00);
    u_host.wr(IDX_TEST, 8'hFF);
    rc("test slot", IDX_TEST, 8'h00);
    rc("unmapped", 6'h3F, 8'h00);
    @(posedge clk);
    special <= 1'b1;
    u_host.wr(IDX_STATUS, 8'h01);
    rc("status special", IDX_STATUS, 8'hC1);
    special <= 1'b0;
  endtask : t_access

  task automatic t_divider();
    u_host.seq(16'h8000, CMD_WORD_PROGRAM);
    rc("no divider", IDX_STATUS, 8'hD0);
    u_host.wr(IDX_STATUS, 8'h10);
    u_host.wr(IDX_DIVIDER, 8'h04);
    rc("divider", IDX_DIVIDER, 8'h84);
    rc("status cleared", IDX_STATUS, 8'hC0);
  endtask : t_divider

  task automatic t_codes();
    logic [7:0] codes [4] = '{CMD_ERASE_VERIFY, CMD_WORD_PROGRAM, CMD_SECTOR_ERASE, CMD_MASS_ERASE};
    logic [7:0] exp [4] = '{8'hC4, 8'hC0, 8'hC0, 8'hC0};
    @(posedge clk);
    blank <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_host.seq(16'h8000, codes[i]);
      wait_done();
      rc("after code", IDX_STATUS, exp[i]);
    end
    blank <= 1'b0;
  endtask : t_codes

  task automatic t_irq();
    u_host.wr(IDX_CONFIG, 8'hC0);
    chk("empty irq", 8'h01, {7'h00, be_irq});
    chk("done irq", 8'h01, {7'h00, cc_irq});
    u_host.seq(16'h8000, CMD_WORD_PROGRAM);
    u_host.rd(IDX_STATUS, q);
    chk("done irq busy", 8'h00, {7'h00, cc_irq});
    wait_done();
    chk("done irq end", 8'h01, {7'h00, cc_irq});
    u_host.wr(IDX_CONFIG, 8'h00);
    chk("irqs off", 8'h00, {6'h00, be_irq, cc_irq});
  endtask : t_irq

  task automatic t_pipe();
    logic [7:0] v;
    int i;
    u_host.seq(16'h8000, CMD_WORD_PROGRAM);
    u_host.seq(16'h8002, CMD_WORD_PROGRAM);
    rc("queued", IDX_STATUS, 8'h00);
    for (i = 0; i < 40; i++) begin
      u_host.rd(IDX_STATUS, v);
      if (v[ST_BUF_EMPTY] === 1'b1) break;
    end
    chk("fetched", 8'h80, v & 8'hC0);
    wait_done();
    rc("drained", IDX_STATUS, 8'hC0);
  endtask : t_pipe

  task automatic t_bad_seq();
    u_host.arr(16'h8000);
    u_host.wr(IDX_STATUS, 8'h00);
    rc("abort", IDX_STATUS, 8'hD0);
    u_host.wr(IDX_STATUS, 8'h10);
    u_host.wr(IDX_STATUS, 8'h00);
    rc("zero outside", IDX_STATUS, 8'hC0);
    u_host.arr(16'h8000);
    u_host.wr(IDX_COMMAND, 8'hFF);
    rc("command bits", IDX_COMMAND, 8'h65);
    u_host.wr(IDX_STATUS, 8'h80);
    rc("bad code", IDX_STATUS, 8'hD0);
    u_host.wr(IDX_STATUS, 8'h10);
  endtask : t_bad_seq

  task automatic t_stop();
    u_host.seq(16'h8000, CMD_ERASE_VERIFY);
    @(posedge clk);
    cpu_stop <= 1'b1;
    @(posedge clk);
    cpu_stop <= 1'b0;
    wait_done();
    rc("stop", IDX_STATUS, 8'hD0);
    u_host.wr(IDX_STATUS, 8'h10);
  endtask : t_stop

  task automatic t_special();
    @(posedge clk);
    special <= 1'b1;
    u_host.seq(16'h8000, CMD_ERASE_VERIFY);
    u_host.rd(IDX_STATUS, q);
    chk("idle busy", 8'h00, q & 8'h7F);
    wait_done();
    rc("verify fail", IDX_STATUS, 8'hC3);
    u_host.seq(16'h8000, CMD_WORD_PROGRAM);
    rc("blocked", IDX_STATUS, 8'hD3);
    u_host.wr(IDX_STATUS, 8'h12);
    rc("cleared", IDX_STATUS, 8'hC1);
    special <= 1'b0;
  endtask : t_special

  task automatic t_prot();
    for (int s = 0; s < 8; s++) begin
      for (int t = 0; t < 8; t++) begin
        do_reset();
        u_host.wr(IDX_PROTECT, enc(s[2:0]));
        u_host.wr(IDX_PROTECT, enc(t[2:0]));
        rc("protection", IDX_PROTECT, OK_TO[s][t] ? enc(t[2:0]) : enc(s[2:0]));
      end
    end
  endtask : t_prot

  task automatic t_viol();
    do_reset();
    u_host.wr(IDX_DIVIDER, 8'h04);
    // scenario 5 protects the high range, 0xC000 up with the largest size
    u_host.wr(IDX_PROTECT, 8'hDF);
    u_host.seq(16'hC000, CMD_WORD_PROGRAM);
    u_host.rd(IDX_STATUS, q);
    chk("violation", 8'hE0, q & 8'hE0);
    u_host.seq(16'h8000, CMD_WORD_PROGRAM);
    u_host.rd(IDX_STATUS, q);
    chk("launch blocked", 8'h30, q & 8'h30);
    u_host.wr(IDX_STATUS, 8'h30);
    rc("flags cleared", IDX_STATUS, 8'hC0);
  endtask : t_viol

  initial begin
    rst = 1'b1;
    special = 1'b0;
    cpu_stop = 1'b0;
    blank = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_access();
    t_divider();
    t_codes();
    t_irq();
    t_pipe();
    t_bad_seq();
    t_stop();
    t_special();
    t_prot();
    t_viol();
    wrap_up();
  end
endmodule : test_flash_command_status_protect
`default_nettype wire
